// ---- hw/local_remote_param_cmd_frames.sv ----
// parser for local, queued and remote parameter command frames
//
// Overview of operation
// RULE_01: the two bytes after the delimiter give the payload length, high byte first.
// RULE_02: the last byte is 0xff minus the 8-bit sum of bytes from offset 3 to the payload end.
// RULE_03: a type 0x08 frame queries or sets a local parameter and then applies all pending changes.
// RULE_04: local frames carry the two-character parameter name at offsets 5 and 6.
// RULE_05: bytes after the name form a new value, no bytes means a read.
// RULE_06: type 0x09 values are held pending until a type 0x08 frame or the apply command.
// RULE_07: a type 0x09 frame with no value is answered as a read at once.
// RULE_08: a value may come in minimal width or zero-extended to two or four bytes.
// RULE_09: a type 0x07 frame addresses a remote module with its name at offsets 14 and 15.
// RULE_10: offsets 5 to 12 are a 64-bit destination whose upper four bytes are zero.
// RULE_11: option byte at offset 13, bit value 0x02 asks the remote to apply changes.
// RULE_12: the byte at offset 3 is the frame type and steers the payload decode.
// RULE_13: the frame id after the type is echoed, and zero suppresses the response.
// RULE_14: every multi-byte field is sent most significant byte first.
// RULE_15: a frame is good only when the sum from offset 3 through the checksum is 0xff.
// RULE_16: a failing frame is discarded and leaves parameter state untouched.
`timescale 1ns/100ps
module local_remote_param_cmd_frames (
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   input  wire logic        rx_valid,
   input  wire logic [7:0]  rx_byte,
   output logic             rd_valid_q,
   output logic [15:0]      rd_name_q,
   output logic [7:0]       rd_frame_id_q,
   output logic             rd_respond_q,
   output logic             param_wr_valid_q,
   output logic [15:0]      param_wr_name_q,
   output logic [31:0]      param_wr_value_q,
   output logic [7:0]       param_wr_len_q,
   output logic             apply_done_q,
   output logic             remote_valid_q,
   output logic [31:0]      remote_ip_q,
   output logic             remote_apply_q,
   output logic [15:0]      remote_name_q,
   output logic [31:0]      remote_value_q,
   output logic [7:0]       remote_len_q,
   output logic [7:0]       remote_frame_id_q,
   output logic             remote_respond_q,
   output logic             frame_error_q,
   output logic             queue_full_q
);
   typedef enum logic [2:0] {S_DELIM, S_LEN_HI, S_LEN_LO, S_DATA, S_CSUM} parse_t;
   typedef enum logic [1:0] {D_IDLE, D_RUN, D_DONE} drain_t;

   parse_t      st_q;
   drain_t      dst_q;
   logic [15:0] len_q;
   logic [15:0] idx_q;
   logic [7:0]  sum_q;
   logic [7:0]  type_q;
   logic [7:0]  fid_q;
   logic [15:0] name_q;
   logic [31:0] val_q;
   logic [7:0]  vlen_q;
   logic        dest_hi_nz_q;
   logic [31:0] ip_q;
   logic [7:0]  opt_q;
   logic [3:0]  wr_ptr_q;
   logic [3:0]  rd_ptr_q;
   logic [3:0]  drain_end_q;
   logic        apply_req_q;
   logic        issue_q;
   logic [param_cmd_pkg::ENTRY_W-1:0] rd_data_q;

   function automatic logic [7:0] add8(input logic [7:0] a, input logic [7:0] b);
      logic [8:0] s;
      s = {1'b0, a} + {1'b0, b};
      return s[7:0];
   endfunction : add8

   function automatic logic [15:0] inc16(input logic [15:0] a);
      logic [16:0] s;
      s = {1'b0, a} + 17'h00001;
      return s[15:0];
   endfunction : inc16

   // value start and name positions depend on the type byte
   wire logic        is_remote  = (type_q == param_cmd_pkg::TYPE_REMOTE); // RULE_12
   wire logic        is_local   = (type_q == param_cmd_pkg::TYPE_LOCAL);
   wire logic        is_queued  = (type_q == param_cmd_pkg::TYPE_QUEUED);
   wire logic        is_loc_any = is_local | is_queued;
   wire logic [15:0] val_idx    = is_remote ? param_cmd_pkg::IDX_REM_VAL :
                                              param_cmd_pkg::IDX_LOC_VAL;
   wire logic [15:0] last_idx   = len_q - 16'h0001;
   wire logic [7:0]  sum_w      = add8(sum_q, rx_byte);
   wire logic        fin        = (st_q == S_CSUM) && rx_valid;
   wire logic        csum_ok    = (sum_w == param_cmd_pkg::CSUM_GOOD); // RULE_15 RULE_02
   wire logic        len_ok     = is_remote ? (len_q >= param_cmd_pkg::IDX_REM_VAL) :
                                              (len_q >= param_cmd_pkg::IDX_LOC_VAL);
   wire logic        good       = csum_ok && len_ok && !(is_remote && dest_hi_nz_q); // RULE_10
   wire logic        is_apply   = (name_q == param_cmd_pkg::APPLY_CMD_NAME);
   wire logic        has_val    = (vlen_q != 8'h00);
   wire logic [3:0]  q_cnt      = wr_ptr_q - rd_ptr_q;
   wire logic        q_full     = (q_cnt == param_cmd_pkg::QUEUE_FULL_CNT);
   wire logic        want_enq   = fin && good && is_loc_any && has_val && !is_apply; // RULE_05
   wire logic        enq        = want_enq && !q_full; // RULE_16
   wire logic        rd_ev      = fin && good && is_loc_any && !has_val && !is_apply; // RULE_07
   // a write refused for a full store must not trigger an apply either
   wire logic        apply_ev   = fin && good && (is_local || (is_queued && is_apply)) &&
                                  !(want_enq && q_full); // RULE_03 RULE_06 RULE_16
   wire logic        remote_ev  = fin && good && is_remote; // RULE_09
   wire logic        err_ev     = (fin && !good) || (want_enq && q_full) ||
                                  ((st_q == S_LEN_LO) && rx_valid && (len_q[15:8] == 8'h00) &&
                                   (rx_byte == 8'h00));
   wire logic        rd_issue   = (dst_q == D_RUN) && (rd_ptr_q != drain_end_q);

   // frame walk
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         st_q  <= S_DELIM;
         len_q <= 16'h0000;
         idx_q <= 16'h0000;
         sum_q <= 8'h00;
      end else if (rx_valid) begin
         unique case (st_q)
            S_DELIM: begin
               if (rx_byte == param_cmd_pkg::FRAME_DELIM) begin
                  st_q <= S_LEN_HI;
               end
            end
            S_LEN_HI: begin
               len_q[15:8] <= rx_byte; // RULE_01 RULE_14
               st_q        <= S_LEN_LO;
            end
            S_LEN_LO: begin
               len_q[7:0] <= rx_byte; // RULE_01
               idx_q      <= 16'h0000;
               sum_q      <= 8'h00;
               st_q       <= ({len_q[15:8], rx_byte} == 16'h0000) ? S_DELIM : S_DATA;
            end
            S_DATA: begin
               sum_q <= sum_w;
               idx_q <= inc16(idx_q);
               if (idx_q == last_idx) begin
                  st_q <= S_CSUM;
               end
            end
            S_CSUM: begin
               st_q <= S_DELIM;
            end
         endcase
      end
   end

   // payload field capture
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         type_q       <= 8'h00;
         fid_q        <= 8'h00;
         name_q       <= 16'h0000;
         val_q        <= 32'h00000000;
         vlen_q       <= 8'h00;
         dest_hi_nz_q <= 1'b0;
         ip_q         <= 32'h00000000;
         opt_q        <= 8'h00;
      end else if (rx_valid && (st_q == S_LEN_LO)) begin
         val_q        <= 32'h00000000;
         vlen_q       <= 8'h00;
         dest_hi_nz_q <= 1'b0;
      end else if (rx_valid && (st_q == S_DATA)) begin
         if (idx_q == param_cmd_pkg::IDX_TYPE) begin
            type_q <= rx_byte; // RULE_12
         end
         if (idx_q == param_cmd_pkg::IDX_FID) begin
            fid_q <= rx_byte; // RULE_13
         end
         if (idx_q >= val_idx) begin
            val_q  <= {val_q[23:0], rx_byte}; // RULE_08 RULE_14
            vlen_q <= (vlen_q == param_cmd_pkg::VLEN_MAX) ? vlen_q : vlen_q + 8'h01;
         end
         if (is_remote) begin
            if ((idx_q >= param_cmd_pkg::IDX_REM_DEST) &&
                (idx_q <= param_cmd_pkg::IDX_REM_DEST_HI) && (rx_byte != 8'h00)) begin
               dest_hi_nz_q <= 1'b1; // RULE_10
            end
            if ((idx_q > param_cmd_pkg::IDX_REM_DEST_HI) &&
                (idx_q <= param_cmd_pkg::IDX_REM_DEST_END)) begin
               ip_q <= {ip_q[23:0], rx_byte}; // RULE_10
            end
            if (idx_q == param_cmd_pkg::IDX_REM_OPT) begin
               opt_q <= rx_byte; // RULE_11
            end
            if (idx_q == param_cmd_pkg::IDX_REM_NAME_HI) begin
               name_q[15:8] <= rx_byte; // RULE_09
            end
            if (idx_q == param_cmd_pkg::IDX_REM_NAME_LO) begin
               name_q[7:0] <= rx_byte; // RULE_09
            end
         end else begin
            if (idx_q == param_cmd_pkg::IDX_LOC_NAME_HI) begin
               name_q[15:8] <= rx_byte; // RULE_04
            end
            if (idx_q == param_cmd_pkg::IDX_LOC_NAME_LO) begin
               name_q[7:0] <= rx_byte; // RULE_04
            end
         end
      end
   end

   // read, remote and error events
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         rd_valid_q        <= 1'b0;
         rd_name_q         <= 16'h0000;
         rd_frame_id_q     <= 8'h00;
         rd_respond_q      <= 1'b0;
         remote_valid_q    <= 1'b0;
         remote_ip_q       <= 32'h00000000;
         remote_apply_q    <= 1'b0;
         remote_name_q     <= 16'h0000;
         remote_value_q    <= 32'h00000000;
         remote_len_q      <= 8'h00;
         remote_frame_id_q <= 8'h00;
         remote_respond_q  <= 1'b0;
         frame_error_q     <= 1'b0;
      end else begin
         rd_valid_q     <= rd_ev; // RULE_07
         remote_valid_q <= remote_ev;
         frame_error_q  <= err_ev; // RULE_16
         if (rd_ev) begin
            rd_name_q     <= name_q;
            rd_frame_id_q <= fid_q;
            rd_respond_q  <= (fid_q != param_cmd_pkg::FID_SILENT); // RULE_13
         end
         if (remote_ev) begin
            remote_ip_q       <= ip_q;
            remote_apply_q    <= opt_q[param_cmd_pkg::OPT_APPLY_BIT]; // RULE_11
            remote_name_q     <= name_q;
            remote_value_q    <= val_q;
            remote_len_q      <= vlen_q;
            remote_frame_id_q <= fid_q;
            remote_respond_q  <= (fid_q != param_cmd_pkg::FID_SILENT); // RULE_13
         end
      end
   end

   // pending store write side
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         wr_ptr_q     <= 4'h0;
         apply_req_q  <= 1'b0;
         queue_full_q <= 1'b0;
      end else begin
         wr_ptr_q     <= enq ? wr_ptr_q + 4'h1 : wr_ptr_q; // RULE_06
         apply_req_q  <= apply_ev; // RULE_03
         queue_full_q <= q_full;
      end
   end

   // apply: drain everything queued up to the apply request
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         dst_q        <= D_IDLE;
         rd_ptr_q     <= 4'h0;
         drain_end_q  <= 4'h0;
         issue_q      <= 1'b0;
         apply_done_q <= 1'b0;
      end else begin
         issue_q      <= rd_issue;
         apply_done_q <= 1'b0;
         if (rd_issue) begin
            rd_ptr_q <= rd_ptr_q + 4'h1;
         end
         if (apply_req_q) begin
            drain_end_q <= wr_ptr_q; // RULE_03 RULE_06
         end
         unique case (dst_q)
            D_IDLE: begin
               if (apply_req_q) begin
                  dst_q <= D_RUN;
               end
            end
            D_RUN: begin
               if (!rd_issue && !apply_req_q) begin
                  dst_q <= D_DONE;
               end
            end
            D_DONE: begin
               apply_done_q <= 1'b1;
               // an apply landing here starts a fresh drain instead of being lost
               dst_q        <= apply_req_q ? D_RUN : D_IDLE; // RULE_03
            end
         endcase
      end
   end

   // applied parameter writes
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         param_wr_valid_q <= 1'b0;
         param_wr_name_q  <= 16'h0000;
         param_wr_value_q <= 32'h00000000;
         param_wr_len_q   <= 8'h00;
      end else begin
         param_wr_valid_q <= issue_q;
         if (issue_q) begin
            {param_wr_name_q, param_wr_value_q, param_wr_len_q} <= rd_data_q;
         end
      end
   end

   param_pending_mem u_mem (
      .clk_sys   (clk_sys),
      .wr_en     (enq),
      .wr_addr   (wr_ptr_q[param_cmd_pkg::QUEUE_AW-1:0]),
      .wr_data   ({name_q, val_q, vlen_q}),
      .rd_en     (rd_issue),
      .rd_addr   (rd_ptr_q[param_cmd_pkg::QUEUE_AW-1:0]),
      .rd_data_q (rd_data_q)
   );

   property p_len_lo;
      @(posedge clk_sys) disable iff (!rst_n)
      (st_q == S_LEN_LO && rx_valid) |=> (len_q[7:0] == $past(rx_byte)) && (st_q != S_LEN_HI);
   endproperty
   a_len_lo: assert property (p_len_lo) else $error("length low byte not kept"); // RULE_01

   property p_csum_gate;
      @(posedge clk_sys) disable iff (!rst_n)
      (rd_valid_q || remote_valid_q) |-> $past(fin && csum_ok);
   endproperty
   a_csum_gate: assert property (p_csum_gate) else $error("event without good checksum"); // RULE_15

   property p_err_no_write;
      @(posedge clk_sys) disable iff (!rst_n)
      frame_error_q |-> (wr_ptr_q == $past(wr_ptr_q)) && !apply_req_q;
   endproperty
   a_err_no_write: assert property (p_err_no_write) else $error("bad frame changed state"); // RULE_16

   property p_queued_read;
      @(posedge clk_sys) disable iff (!rst_n)
      (fin && good && is_queued && !has_val && !is_apply) |=> rd_valid_q && !apply_req_q;
   endproperty
   a_queued_read: assert property (p_queued_read) else $error("queued read not answered"); // RULE_07

   property p_local_apply;
      @(posedge clk_sys) disable iff (!rst_n)
      (fin && good && is_local && !(want_enq && q_full)) |=> apply_req_q ##1 (dst_q == D_RUN);
   endproperty
   a_local_apply: assert property (p_local_apply) else $error("local frame did not apply"); // RULE_03

   property p_queued_hold;
      @(posedge clk_sys) disable iff (!rst_n)
      (enq && is_queued && dst_q == D_IDLE && !apply_req_q) |=> (dst_q == D_IDLE) && !issue_q;
   endproperty
   a_queued_hold: assert property (p_queued_hold) else $error("queued value applied early"); // RULE_06

   property p_no_value_no_queue;
      @(posedge clk_sys) disable iff (!rst_n)
      (fin && !has_val) |=> (wr_ptr_q == $past(wr_ptr_q));
   endproperty
   a_no_value_no_queue: assert property (p_no_value_no_queue) else $error("read was queued"); // RULE_05

   property p_dest_upper;
      @(posedge clk_sys) disable iff (!rst_n)
      (fin && is_remote && dest_hi_nz_q) |=> !remote_valid_q && frame_error_q;
   endproperty
   a_dest_upper: assert property (p_dest_upper) else $error("nonzero upper dest accepted"); // RULE_10

   property p_remote_apply;
      @(posedge clk_sys) disable iff (!rst_n)
      remote_valid_q |-> (remote_apply_q == $past(opt_q[param_cmd_pkg::OPT_APPLY_BIT]));
   endproperty
   a_remote_apply: assert property (p_remote_apply) else $error("apply option lost"); // RULE_11

   property p_respond;
      @(posedge clk_sys) disable iff (!rst_n)
      rd_valid_q |-> (rd_respond_q == (rd_frame_id_q != 8'h00));
   endproperty
   a_respond: assert property (p_respond) else $error("response flag mismatch"); // RULE_13
endmodule : local_remote_param_cmd_frames

// ---- hw/param_cmd_pkg.sv ----
// constants for the parameter command frame parser
package param_cmd_pkg;
   // framing bytes and frame types
   localparam logic [7:0]  FRAME_DELIM      = 8'h7e;
   localparam logic [7:0]  TYPE_REMOTE      = 8'h07;
   localparam logic [7:0]  TYPE_LOCAL       = 8'h08;
   localparam logic [7:0]  TYPE_QUEUED      = 8'h09;
   localparam logic [7:0]  CSUM_GOOD        = 8'hff;
   localparam logic [7:0]  FID_SILENT       = 8'h00;
   // two ascii characters of the apply command
   localparam logic [15:0] APPLY_CMD_NAME   = 16'h4143;
   // payload indices, counted from the type byte at frame offset 3
   localparam logic [15:0] IDX_TYPE         = 16'h0000;
   localparam logic [15:0] IDX_FID          = 16'h0001;
   localparam logic [15:0] IDX_LOC_NAME_HI  = 16'h0002;
   localparam logic [15:0] IDX_LOC_NAME_LO  = 16'h0003;
   localparam logic [15:0] IDX_LOC_VAL      = 16'h0004;
   localparam logic [15:0] IDX_REM_DEST     = 16'h0002;
   localparam logic [15:0] IDX_REM_DEST_HI  = 16'h0005;
   localparam logic [15:0] IDX_REM_DEST_END = 16'h0009;
   localparam logic [15:0] IDX_REM_OPT      = 16'h000a;
   localparam logic [15:0] IDX_REM_NAME_HI  = 16'h000b;
   localparam logic [15:0] IDX_REM_NAME_LO  = 16'h000c;
   localparam logic [15:0] IDX_REM_VAL      = 16'h000d;
   localparam int          OPT_APPLY_BIT    = 1;
   // pending change store
   localparam int          QUEUE_AW         = 3;
   localparam int          QUEUE_DEPTH      = 8;
   localparam int          ENTRY_W          = 56;
   localparam logic [3:0]  QUEUE_FULL_CNT   = 4'h8;
   localparam logic [7:0]  VLEN_MAX         = 8'hff;
endpackage : param_cmd_pkg

// ---- hw/param_pending_mem.sv ----
// small memory that holds queued parameter changes
`timescale 1ns/100ps
module param_pending_mem (
   input  wire logic                                 clk_sys,
   input  wire logic                                 wr_en,
   input  wire logic [param_cmd_pkg::QUEUE_AW-1:0]   wr_addr,
   input  wire logic [param_cmd_pkg::ENTRY_W-1:0]    wr_data,
   input  wire logic                                 rd_en,
   input  wire logic [param_cmd_pkg::QUEUE_AW-1:0]   rd_addr,
   output logic      [param_cmd_pkg::ENTRY_W-1:0]    rd_data_q
);
   logic [param_cmd_pkg::ENTRY_W-1:0] mem_q [param_cmd_pkg::QUEUE_DEPTH];

   always_ff @(posedge clk_sys) begin
      if (wr_en) begin
         mem_q[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rd_en) begin
         rd_data_q <= mem_q[rd_addr];
      end
   end
endmodule : param_pending_mem

// ---- testbench/host_frame_model.sv ----
// host side model that sends parameter command frames one byte per cycle or slower
`timescale 1ns/100ps
module host_frame_model (
   input  wire logic        clk_sys,
   output logic             rx_valid,
   output logic [7:0]       rx_byte
);
   int gap      = 0;
   int cyc      = 0;
   int last_cyc = 0;

   initial begin
      rx_valid = 1'b0;
      rx_byte  = 8'h00;
   end

   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
   end

   // byte held until the taking edge, then line shows the inverse while idle
   task automatic put(input logic [7:0] b);
      rx_valid = 1'b1;
      rx_byte  = b;
      @(posedge clk_sys);
      last_cyc = cyc;
      #1;
      if (gap > 0) begin
         rx_valid = 1'b0;
         rx_byte  = ~b;
         repeat (gap) @(posedge clk_sys);
         #1;
      end
   endtask : put

   task automatic send(input logic [7:0] pl[$], input bit bad);
      logic [7:0]  sum;
      logic [15:0] len;
      sum = 8'h00;
      len = 16'(pl.size());
      // one idle edge so a release never meets the next delimiter in one step
      @(posedge clk_sys);
      #1;
      put(8'h7e);
      put(len[15:8]);
      put(len[7:0]);
      foreach (pl[i]) begin
         put(pl[i]);
         sum = sum + pl[i];
      end
      put(8'hff - sum + {7'h00, bad});
      rx_valid = 1'b0;
      rx_byte  = ~rx_byte;
   endtask : send
endmodule : host_frame_model

// ---- testbench/local_remote_param_cmd_frames_tb_top.sv ----
// self-checking bench for the parameter command frame parser
`timescale 1ns/100ps
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin failures++; \
   $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module local_remote_param_cmd_frames_tb_top;
   logic        clk_sys, rst_n, rx_valid;
   logic [7:0]  rx_byte;
   logic        rd_valid_q, rd_respond_q, param_wr_valid_q, apply_done_q, remote_valid_q;
   logic        remote_apply_q, remote_respond_q, frame_error_q, queue_full_q;
   logic [15:0] rd_name_q, param_wr_name_q, remote_name_q;
   logic [7:0]  rd_frame_id_q, param_wr_len_q, remote_len_q, remote_frame_id_q;
   logic [31:0] param_wr_value_q, remote_ip_q, remote_value_q;
   logic [55:0] wr_q[$];
   int          failures = 0;
   int          cmp_count = 0;
   int          rd_n, rem_n, err_n, done_n, rd_cyc, rem_cyc, done_cyc;

   local_remote_param_cmd_frames dut (
      .clk_sys(clk_sys), .rst_n(rst_n), .rx_valid(rx_valid), .rx_byte(rx_byte),
      .rd_valid_q(rd_valid_q), .rd_name_q(rd_name_q), .rd_frame_id_q(rd_frame_id_q),
      .rd_respond_q(rd_respond_q), .param_wr_valid_q(param_wr_valid_q),
      .param_wr_name_q(param_wr_name_q), .param_wr_value_q(param_wr_value_q),
      .param_wr_len_q(param_wr_len_q), .apply_done_q(apply_done_q),
      .remote_valid_q(remote_valid_q), .remote_ip_q(remote_ip_q),
      .remote_apply_q(remote_apply_q), .remote_name_q(remote_name_q),
      .remote_value_q(remote_value_q), .remote_len_q(remote_len_q),
      .remote_frame_id_q(remote_frame_id_q), .remote_respond_q(remote_respond_q),
      .frame_error_q(frame_error_q), .queue_full_q(queue_full_q));

   host_frame_model host (.clk_sys(clk_sys), .rx_valid(rx_valid), .rx_byte(rx_byte));

   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end

   // pulse monitor, cycle stamps share the host's edge count
   always @(posedge clk_sys) begin
      if (param_wr_valid_q === 1'b1) wr_q.push_back({param_wr_name_q, param_wr_value_q,
                                                     param_wr_len_q});
      if (rd_valid_q === 1'b1) begin rd_n++; rd_cyc = host.cyc; end
      if (remote_valid_q === 1'b1) begin rem_n++; rem_cyc = host.cyc; end
      if (frame_error_q === 1'b1) err_n++;
      if (apply_done_q === 1'b1) begin done_n++; done_cyc = host.cyc; end
   end

   task automatic clear();
      wr_q.delete();
      rd_n = 0; rem_n = 0; err_n = 0; done_n = 0;
   endtask : clear

   task automatic settle();
      repeat (20) @(posedge clk_sys);
      #1;
   endtask : settle

   task automatic t_queue_apply();
      clear();
      host.send('{8'h09, 8'h01, 8'h42, 8'h44, 8'h07}, 1'b0);
      settle();
      `CHK(wr_q.size(), 0)
      host.send('{8'h08, 8'h02, 8'h41, 8'h43}, 1'b0);
      settle();
      `CHK(wr_q.size(), 1)
      `CHK(wr_q[0], {16'h4244, 32'h0000_0007, 8'h01})
      `CHK(done_n, 1)
      `CHK(done_cyc - host.last_cyc, 5)
      `CHK(rd_n, 0)
   endtask : t_queue_apply

   task automatic t_widths();
      clear();
      host.gap = 2;
      host.send('{8'h09, 8'h01, 8'h4e, 8'h49, 8'h07}, 1'b0);
      host.gap = 0;
      host.send('{8'h09, 8'h01, 8'h4e, 8'h49, 8'h00, 8'h07}, 1'b0);
      host.send('{8'h09, 8'h01, 8'h4e, 8'h49, 8'h00, 8'h00, 8'h00, 8'h07}, 1'b0);
      host.send('{8'h08, 8'h01, 8'h42, 8'h44, 8'h00, 8'h08}, 1'b0);
      settle();
      `CHK(wr_q.size(), 4)
      for (int i = 0; i < 3; i++) begin
         `CHK(wr_q[i], {16'h4e49, 32'h0000_0007, 8'(i == 2 ? 4 : i + 1)})
      end
      `CHK(wr_q[3], {16'h4244, 32'h0000_0008, 8'h02})
   endtask : t_widths

   task automatic t_read();
      clear();
      host.send('{8'h09, 8'h05, 8'h4e, 8'h49}, 1'b0);
      `CHK(rd_n, 0)
      @(posedge clk_sys);
      #1;
      `CHK(rd_n, 1)
      `CHK(rd_cyc - host.last_cyc, 1)
      `CHK({rd_name_q, rd_frame_id_q, rd_respond_q}, {16'h4e49, 8'h05, 1'b1})
      host.send('{8'h08, 8'h00, 8'h44, 8'h4c}, 1'b0);
      settle();
      `CHK({rd_name_q, rd_frame_id_q, rd_respond_q}, {16'h444c, 8'h00, 1'b0})
      `CHK(done_n, 1)
      `CHK(wr_q.size(), 0)
   endtask : t_read

   task automatic t_remote();
      clear();
      host.send('{8'h07, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'hc0, 8'ha8, 8'h00, 8'h64,
                  8'h02, 8'h44, 8'h4c}, 1'b0);
      settle();
      `CHK(rem_n, 1)
      `CHK(rem_cyc - host.last_cyc, 1)
      `CHK(remote_ip_q, 32'hc0a8_0064)
      `CHK({remote_apply_q, remote_name_q, remote_len_q}, {1'b1, 16'h444c, 8'h00})
      `CHK({remote_frame_id_q, remote_respond_q}, {8'h01, 1'b1})
      host.send('{8'h07, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'hc0, 8'ha8, 8'h00, 8'h67,
                  8'h00, 8'h44, 8'h31, 8'h03}, 1'b0);
      settle();
      `CHK({remote_apply_q, remote_name_q}, {1'b0, 16'h4431})
      `CHK({remote_value_q, remote_len_q}, {32'h0000_0003, 8'h01})
      host.send('{8'h07, 8'h04, 8'h01, 8'h00, 8'h00, 8'h00, 8'hc0, 8'ha8, 8'h00, 8'h64,
                  8'h02, 8'h44, 8'h4c}, 1'b0);
      settle();
      `CHK({rem_n, err_n}, {32'd2, 32'd1})
      `CHK(wr_q.size(), 0)
   endtask : t_remote

   task automatic t_discard();
      clear();
      host.send('{8'h09, 8'h01, 8'h42, 8'h44, 8'h07}, 1'b1);
      host.send('{8'h20, 8'h01, 8'h42, 8'h44}, 1'b0);
      settle();
      `CHK(err_n, 1)
      `CHK(rd_n + rem_n + done_n, 0)
      for (int i = 0; i < 8; i++) host.send('{8'h09, 8'h01, 8'h42, 8'h44, 8'(i)}, 1'b0);
      settle();
      `CHK(queue_full_q, 1'b1)
      host.send('{8'h09, 8'h01, 8'h4e, 8'h49, 8'h09}, 1'b0);
      host.send('{8'h09, 8'h01, 8'h41, 8'h43}, 1'b0);
      settle();
      `CHK(err_n, 2)
      `CHK(wr_q.size(), 8)
      `CHK(wr_q[7], {16'h4244, 32'h0000_0007, 8'h01})
      `CHK(queue_full_q, 1'b0)
   endtask : t_discard

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : test_done

   initial begin
      rst_n = 1'b0;
      repeat (8) @(posedge clk_sys);
      #1;
      rst_n = 1'b1;
      `CHK({rd_valid_q, param_wr_valid_q, frame_error_q, queue_full_q}, 4'h0)
      t_queue_apply();
      t_widths();
      t_read();
      t_remote();
      t_discard();
      test_done();
   end

   // hang guard
   initial begin
      repeat (20000) @(posedge clk_sys);
      failures++;
      test_done();
   end
endmodule : local_remote_param_cmd_frames_tb_top
